// ==== core/cpu_bus_end.sv ====
// Processor end: bus cycles, arbitration, fault termination and re-run.
`timescale 1ns/100ps
`default_nettype none
`include "bus_arb_consts.svh"
module cpu_bus_end (
    input wire logic clk_sys,
    input wire logic sys_rst,
    cpu_bus_if.cpu_end bus,
    input wire logic cyc_start,
    input wire logic cyc_write,
    input wire logic cyc_word,
    input wire logic cyc_tas,
    input wire logic cyc_supervisor,
    input wire logic cyc_program,
    input wire logic cyc_int_ack,
    input wire logic [23:0] cyc_addr,
    input wire logic [15:0] cyc_wdata,
    input wire logic [23:0] stack_ptr,
    input wire logic [23:0] prog_counter,
    input wire logic [15:0] status_word,
    output logic cyc_ready,
    output logic cyc_done,
    output logic exc_done,
    output logic halted,
    output logic [15:0] cyc_rdata,
    output logic [31:0] exc_new_pc
);
    bus_arb_pkg::bus_state_t bus_state, next_bus;
    bus_arb_pkg::arb_state_t arb_state, next_arb;
    logic [4:0] sync_a, sync_b;
    logic [3:0] arb_cnt, next_cnt, exc_step;
    logic [23:0] cur_addr, exc_sp, fault_addr;
    logic [15:0] cur_wdata, fault_stat;
    logic [2:0] cur_fc;
    logic cur_write, cur_word, cur_rmw, rmw_phase, fault_hit, exc_active, gack_d;

    // Two falling-edge stages; rising-edge logic only sees the second
    wire [4:0] raw_in = {!bus.transfer_ack_n, !bus.bus_request_n, !bus.grant_acknowledge_n,
        !bus.bus_fault_in_n, !bus.halt_n};
    always_ff @(negedge clk_sys) begin
        if (sys_rst) begin
            sync_a <= 5'h00;
            sync_b <= 5'h00;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    wire ack_s = sync_b[4];
    wire req_s = sync_b[3];
    wire gack_s = sync_b[2];
    wire fault_s = sync_b[1];
    wire halt_s = sync_b[0];

    // State decode
    wire st_idle = bus_state == bus_arb_pkg::bs_idle;
    wire st_s0 = bus_state == bus_arb_pkg::bs_s0;
    wire st_strb = bus_state == bus_arb_pkg::bs_strb;
    wire st_wait = bus_state == bus_arb_pkg::bs_wait;
    wire st_end = bus_state == bus_arb_pkg::bs_end;
    wire st_mod = bus_state == bus_arb_pkg::bs_mod;
    wire st_float = bus_state == bus_arb_pkg::bs_float;
    wire st_halt = bus_state == bus_arb_pkg::bs_halt;
    wire in_cyc = st_s0 || st_strb || st_wait || st_end;

    // No new cycle while someone asks for or holds the bus
    wire may_start = arb_state == bus_arb_pkg::as_idle && !req_s && !gack_s && !halt_s;
    wire load_exc = st_idle && may_start && exc_active;
    wire load_user = st_idle && may_start && !exc_active && cyc_start;
    wire normal_end = st_end && !fault_hit;
    wire float_exit = st_float && !fault_s;
    assign cyc_ready = st_idle && may_start && !exc_active;

    // Cycle-space code of a user request
    wire [2:0] user_fc = cyc_int_ack ? `FC_INT_ACK :
        {cyc_supervisor, cyc_program, !cyc_program};

    // Exception frame: six pushes downward, then two vector reads
    wire exc_is_write = exc_step <= `EXC_LAST_WRITE;
    wire [23:0] push_addr = exc_sp - {19'h00000, exc_step + 4'h1, 1'b0};
    wire [23:0] exc_addr = exc_is_write ? push_addr :
        (exc_step == `EXC_VEC_HI_STEP) ? `FAULT_VEC_ADDR : `FAULT_VEC_NEXT;
    wire [15:0] exc_data = (exc_step == 4'h0) ? prog_counter[15:0] :
        (exc_step == 4'h1) ? {8'h00, prog_counter[23:16]} :
        (exc_step == 4'h2) ? status_word :
        (exc_step == 4'h3) ? fault_addr[15:0] :
        (exc_step == 4'h4) ? {8'h00, fault_addr[23:16]} : fault_stat;
    // Test-and-set marks the addressed byte's top bit
    wire [15:0] tas_data = cur_addr[0] ? (cyc_rdata | `TAS_LOWER_MASK) :
        (cyc_rdata | `TAS_UPPER_MASK);

    // Bus cycle sequencer
    always_comb begin
        next_bus = bus_state;
        case (bus_state)
            bus_arb_pkg::bs_idle: if (load_exc || load_user) next_bus = bus_arb_pkg::bs_s0;
            bus_arb_pkg::bs_s0: next_bus = bus_arb_pkg::bs_strb;
            bus_arb_pkg::bs_strb: next_bus = bus_arb_pkg::bs_wait;
            bus_arb_pkg::bs_wait: begin
                if (fault_s) next_bus = bus_arb_pkg::bs_end;
                else if (ack_s && cur_rmw && !rmw_phase) next_bus = bus_arb_pkg::bs_mod;
                else if (ack_s) next_bus = bus_arb_pkg::bs_end;
            end
            bus_arb_pkg::bs_mod: next_bus = bus_arb_pkg::bs_strb;
            bus_arb_pkg::bs_end: begin
                if (!fault_hit) next_bus = bus_arb_pkg::bs_idle;
                else if (halt_s && !cur_rmw) next_bus = bus_arb_pkg::bs_halt;
                else next_bus = bus_arb_pkg::bs_float;
            end
            bus_arb_pkg::bs_float: if (!fault_s) next_bus = bus_arb_pkg::bs_idle;
            bus_arb_pkg::bs_halt: if (!halt_s) next_bus = bus_arb_pkg::bs_s0;
            default: next_bus = bus_arb_pkg::bs_idle;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) bus_state <= bus_arb_pkg::bs_idle;
        else bus_state <= next_bus;
    end

    // Cycle record; a halted re-run starts again from it untouched
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cur_addr <= 24'h000000;
            cur_wdata <= 16'h0000;
            cur_fc <= `FC_SUPV_DATA;
            cur_write <= 1'b0;
            cur_word <= 1'b0;
            cur_rmw <= 1'b0;
            rmw_phase <= 1'b0;
        end else if (load_user) begin
            cur_addr <= cyc_addr;
            cur_wdata <= cyc_wdata;
            cur_fc <= user_fc;
            cur_write <= cyc_write && !cyc_tas;
            cur_word <= cyc_word && !cyc_tas;
            cur_rmw <= cyc_tas;
            rmw_phase <= 1'b0;
        end else if (load_exc) begin
            cur_addr <= exc_addr;
            cur_wdata <= exc_data;
            cur_fc <= `FC_SUPV_DATA;
            cur_write <= exc_is_write;
            cur_word <= 1'b1;
            cur_rmw <= 1'b0;
            rmw_phase <= 1'b0;
        end else if (st_mod) begin
            cur_wdata <= tas_data;
            cur_write <= 1'b1;
            rmw_phase <= 1'b1;
        end
    end

    // Read data and fault mark
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cyc_rdata <= 16'h0000;
            fault_hit <= 1'b0;
        end else begin
            if (st_wait && ack_s && !fault_s && !cur_write) cyc_rdata <= bus.data_in;
            if (st_wait && fault_s) fault_hit <= 1'b1;
            else if (float_exit || (st_halt && !halt_s)) fault_hit <= 1'b0;
        end
    end

    // Exception stacking starts only once the fault input is released
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            exc_active <= 1'b0;
            exc_step <= 4'h0;
            exc_sp <= 24'h000000;
            fault_addr <= 24'h000000;
            fault_stat <= 16'h0000;
            exc_new_pc <= 32'h00000000;
        end else if (float_exit) begin
            exc_active <= 1'b1;
            exc_step <= 4'h0;
            exc_sp <= stack_ptr;
            fault_addr <= cur_addr;
            fault_stat <= {11'h000, cur_rmw, !cur_write, cur_fc};
        end else if (normal_end && exc_active) begin
            if (exc_step == `EXC_VEC_HI_STEP) exc_new_pc[31:16] <= cyc_rdata;
            if (exc_step == `EXC_LAST_STEP) exc_new_pc[15:0] <= cyc_rdata;
            if (exc_step == `EXC_LAST_STEP) exc_active <= 1'b0;
            else exc_step <= exc_step + 4'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cyc_done <= 1'b0;
            exc_done <= 1'b0;
        end else begin
            cyc_done <= normal_end && !exc_active;
            exc_done <= normal_end && exc_active && exc_step == `EXC_LAST_STEP;
        end
    end

    // Arbiter: grant as soon as possible, but not while S0 is under way
    wire gack_rise = gack_s && !gack_d;
    always_comb begin
        next_arb = arb_state;
        next_cnt = arb_cnt;
        case (arb_state)
            bus_arb_pkg::as_idle: if (req_s && !st_s0) next_arb = bus_arb_pkg::as_grant;
            bus_arb_pkg::as_grant: begin
                if (gack_rise) begin
                    next_arb = bus_arb_pkg::as_owned;
                    next_cnt = 4'h0;
                end else if (!req_s) next_arb = bus_arb_pkg::as_idle;
            end
            bus_arb_pkg::as_owned: begin
                if (arb_cnt == `GRANT_HOLD_CYC) begin
                    next_arb = bus_arb_pkg::as_regrant;
                    next_cnt = 4'h0;
                end else next_cnt = arb_cnt + 4'h1;
            end
            bus_arb_pkg::as_regrant: begin
                if (arb_cnt != `REGRANT_CYC) next_cnt = arb_cnt + 4'h1;
                else if (req_s) next_arb = bus_arb_pkg::as_grant;
                else if (!gack_s) next_arb = bus_arb_pkg::as_idle;
            end
            default: next_arb = bus_arb_pkg::as_idle;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            arb_state <= bus_arb_pkg::as_idle;
            arb_cnt <= 4'h0;
            gack_d <= 1'b0;
        end else begin
            arb_state <= next_arb;
            arb_cnt <= next_cnt;
            gack_d <= gack_s;
        end
    end

    // Pin drive; tri-state control is true while another master holds the bus
    wire as_on = st_strb || st_wait || st_mod;
    wire strobe_on = st_strb || st_wait;
    wire tri_ctl = gack_s && !as_on;
    wire idle_halt = st_halt || (st_idle && halt_s);
    wire float_ad = tri_ctl || st_float || idle_halt;
    assign bus.addr = cur_addr[23:1];
    assign bus.addr_oe_n = float_ad;
    assign bus.data_out = cur_wdata;
    assign bus.data_oe_n = !(cur_write && in_cyc) || float_ad;
    assign bus.address_strobe_n = !as_on;
    assign bus.upper_byte_strobe_n = !(strobe_on && (cur_word || !cur_addr[0]));
    assign bus.lower_byte_strobe_n = !(strobe_on && (cur_word || cur_addr[0]));
    assign bus.read_write = !(cur_write && in_cyc);
    assign bus.ctl_oe_n = tri_ctl;
    assign bus.cycle_space_code = cur_fc;
    assign bus.fc_oe_n = tri_ctl || idle_halt;
    assign bus.bus_grant_n = !(arb_state == bus_arb_pkg::as_grant ||
        arb_state == bus_arb_pkg::as_owned);
    assign halted = idle_halt;
endmodule : cpu_bus_end
`default_nettype wire

// ==== core/bus_arb_consts.svh ====
// Numeric constants shared by both ends of the processor bus.
`ifndef BUS_ARB_CONSTS_SVH
`define BUS_ARB_CONSTS_SVH
`define FC_USER_DATA 3'h1
`define FC_USER_PROG 3'h2
`define FC_SUPV_DATA 3'h5
`define FC_SUPV_PROG 3'h6
`define FC_INT_ACK 3'h7
`define FAULT_VEC_ADDR 24'h000008
`define FAULT_VEC_NEXT 24'h00000A
`define EXC_LAST_WRITE 4'h5
`define EXC_VEC_HI_STEP 4'h6
`define EXC_LAST_STEP 4'h7
`define TAS_UPPER_MASK 16'h8000
`define TAS_LOWER_MASK 16'h0080
`define GRANT_HOLD_CYC 4'h2
`define REGRANT_CYC 4'h2
`define CLK_PERIOD_NS 4
`define FAULT_WATCH_NS 200
`define FAULT_WATCH_CYC ((`FAULT_WATCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_TO_HALT_CYC 1
`define ACK_NEVER 8'hFF
`endif

// ==== core/bus_arb_pkg.sv ====
// State types for the processor bus ends.
package bus_arb_pkg;
    typedef enum logic [7:0] {
        bs_idle = 8'h01, bs_s0 = 8'h02, bs_strb = 8'h04, bs_wait = 8'h08,
        bs_end = 8'h10, bs_mod = 8'h20, bs_float = 8'h40, bs_halt = 8'h80
    } bus_state_t;
    typedef enum logic [3:0] {
        as_idle = 4'h1, as_grant = 4'h2, as_owned = 4'h4, as_regrant = 4'h8
    } arb_state_t;
    typedef enum logic [3:0] {
        ms_idle = 4'h1, ms_req = 4'h2, ms_wait = 4'h4, ms_own = 4'h8
    } master_state_t;
    typedef enum logic [2:0] {
        fs_idle = 3'h1, fs_fault = 3'h2, fs_tail = 3'h4
    } fault_state_t;
endpackage : bus_arb_pkg

// ==== core/cpu_bus_if.sv ====
// Pin-level bundle between the processor end and the external end.
`timescale 1ns/100ps
`default_nettype none
interface cpu_bus_if;
    logic [23:1] addr;
    logic addr_oe_n;
    logic [15:0] data_out;
    logic data_oe_n;
    logic [15:0] data_in;
    logic address_strobe_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic read_write;
    logic ctl_oe_n;
    logic [2:0] cycle_space_code;
    logic fc_oe_n;
    logic transfer_ack_n;
    logic bus_request_n;
    logic bus_grant_n;
    logic grant_acknowledge_n;
    logic bus_fault_in_n;
    logic halt_n;
    modport cpu_end (
        output addr, addr_oe_n, data_out, data_oe_n, address_strobe_n,
        output upper_byte_strobe_n, lower_byte_strobe_n, read_write, ctl_oe_n,
        output cycle_space_code, fc_oe_n, bus_grant_n,
        input data_in, transfer_ack_n, bus_request_n, grant_acknowledge_n,
        input bus_fault_in_n, halt_n
    );
    modport ext_end (
        input addr, addr_oe_n, data_out, data_oe_n, address_strobe_n,
        input upper_byte_strobe_n, lower_byte_strobe_n, read_write, ctl_oe_n,
        input cycle_space_code, fc_oe_n, bus_grant_n,
        output data_in, transfer_ack_n, bus_request_n, grant_acknowledge_n,
        output bus_fault_in_n, halt_n
    );
endinterface : cpu_bus_if
`default_nettype wire

// ==== core/cpu_ext_end.sv ====
// External end: slave responder, fault watchdog and alternate bus master.
`timescale 1ns/100ps
`default_nettype none
`include "bus_arb_consts.svh"
module cpu_ext_end #(
    parameter int WATCH_CYC = `FAULT_WATCH_CYC,
    parameter int HALT_TAIL_CYC = `FAULT_TO_HALT_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    cpu_bus_if.ext_end bus,
    input wire logic want_bus,
    input wire logic [7:0] own_cycles,
    input wire logic [7:0] ack_delay,
    input wire logic rerun_on_fault,
    input wire logic halt_hold,
    input wire logic [15:0] read_value,
    output logic owns_bus,
    output logic fault_issued
);
    // Counters are eight bits wide, so longer spans cannot be served
    if (WATCH_CYC < 2 || WATCH_CYC > 254 ||
        HALT_TAIL_CYC < 1 || HALT_TAIL_CYC > 255) begin : g_bad_timing
        $error("cpu_ext_end: timing parameter out of range");
    end
    localparam logic [7:0] WATCH_LAST = 8'(WATCH_CYC - 1);
    localparam logic [7:0] TAIL_LAST = 8'(HALT_TAIL_CYC - 1);

    bus_arb_pkg::master_state_t m_state, next_m;
    bus_arb_pkg::fault_state_t f_state, next_f;
    logic [7:0] as_cnt, m_cnt, f_cnt;
    logic tack, rerun_flag;

    // Strobe only counts while the processor actually drives it
    wire as_live = !bus.address_strobe_n && !bus.ctl_oe_n;
    wire f_idle = f_state == bus_arb_pkg::fs_idle;
    wire watch_fire = f_idle && as_live && !tack && as_cnt == WATCH_LAST;
    wire ack_ready = ack_delay != `ACK_NEVER && as_cnt >= ack_delay;
    wire m_free = !as_live && !tack && bus.grant_acknowledge_n;

    // Slave side and watchdog share the strobe-age counter
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !as_live) as_cnt <= 8'h00;
        else if (as_cnt != 8'hFF) as_cnt <= as_cnt + 8'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) tack <= 1'b0;
        else tack <= as_live && ack_ready && f_idle;
    end

    // Fault sequencing: hold fault until the strobe drops, then release fault before halt
    always_comb begin
        next_f = f_state;
        case (f_state)
            bus_arb_pkg::fs_idle: if (watch_fire) next_f = bus_arb_pkg::fs_fault;
            bus_arb_pkg::fs_fault: if (!as_live) next_f = bus_arb_pkg::fs_tail;
            bus_arb_pkg::fs_tail: if (f_cnt == TAIL_LAST) next_f = bus_arb_pkg::fs_idle;
            default: next_f = bus_arb_pkg::fs_idle;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            f_state <= bus_arb_pkg::fs_idle;
            f_cnt <= 8'h00;
            rerun_flag <= 1'b0;
        end else begin
            f_state <= next_f;
            f_cnt <= (f_state == bus_arb_pkg::fs_tail) ? f_cnt + 8'h01 : 8'h00;
            if (watch_fire) rerun_flag <= rerun_on_fault;
        end
    end

    // Alternate master: request, wait for a quiet bus, own it, release
    always_comb begin
        next_m = m_state;
        case (m_state)
            bus_arb_pkg::ms_idle: if (want_bus) next_m = bus_arb_pkg::ms_req;
            bus_arb_pkg::ms_req: if (!bus.bus_grant_n) next_m = bus_arb_pkg::ms_wait;
            bus_arb_pkg::ms_wait: if (m_free) next_m = bus_arb_pkg::ms_own;
            bus_arb_pkg::ms_own: if (m_cnt >= own_cycles) next_m = bus_arb_pkg::ms_idle;
            default: next_m = bus_arb_pkg::ms_idle;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            m_state <= bus_arb_pkg::ms_idle;
            m_cnt <= 8'h00;
        end else begin
            m_state <= next_m;
            m_cnt <= (m_state == bus_arb_pkg::ms_own) ? m_cnt + 8'h01 : 8'h00;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) fault_issued <= 1'b0;
        else fault_issued <= watch_fire;
    end

    // Request stays up for the first owned cycle, so it falls after the acknowledge rises
    wire req_on = m_state == bus_arb_pkg::ms_req || m_state == bus_arb_pkg::ms_wait ||
        (m_state == bus_arb_pkg::ms_own && m_cnt == 8'h00);
    wire rerun_halt = rerun_flag && !f_idle;
    assign owns_bus = m_state == bus_arb_pkg::ms_own;
    assign bus.bus_request_n = !req_on;
    assign bus.grant_acknowledge_n = !owns_bus;
    assign bus.transfer_ack_n = !tack;
    assign bus.bus_fault_in_n = f_state != bus_arb_pkg::fs_fault;
    assign bus.halt_n = !(halt_hold || rerun_halt);
    assign bus.data_in = read_value;
endmodule : cpu_ext_end
`default_nettype wire

// ==== verif/cpu_bus_cycle_arbitration_ctrl_checker.sv ====
// Protocol assertions on the wires between the processor end and the external end.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_cycle_arbitration_ctrl_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic addr_oe_n,
    input wire logic data_oe_n,
    input wire logic address_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic read_write,
    input wire logic ctl_oe_n,
    input wire logic [2:0] cycle_space_code,
    input wire logic fc_oe_n,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic grant_acknowledge_n,
    input wire logic bus_fault_in_n
);
    // Either lane strobe asserted
    wire logic lane_on = !(upper_byte_strobe_n && lower_byte_strobe_n);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // Write strobes, locked cycles and cycle codes
    property p_wdata; !ctl_oe_n && !read_write && lane_on |-> !data_oe_n; endproperty
    a_wdata: assert property (p_wdata) else $error("write strobe, data floating");
    property p_rmw; $fell(read_write) && !$past(address_strobe_n) |-> (!address_strobe_n) [*2]; endproperty
    a_rmw: assert property (p_rmw) else $error("locked cycle lost strobe");
    property p_hold; !address_strobe_n |-> !addr_oe_n && !ctl_oe_n; endproperty
    a_hold: assert property (p_hold) else $error("bus released in a cycle");
    property p_code; !address_strobe_n |-> !fc_oe_n && cycle_space_code inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7}; endproperty
    a_code: assert property (p_code) else $error("bad cycle code");
    // Grant timing: two quiet edges for synchronising, one more when caught in S0
    property p_grant;
        $fell(bus_request_n) && bus_grant_n && grant_acknowledge_n
            |-> bus_grant_n ##1 bus_grant_n ##[1:3] !bus_grant_n;
    endproperty
    a_grant: assert property (p_grant) else $error("grant timing");
    property p_ack; $fell(grant_acknowledge_n) |-> ##[1:8] bus_grant_n; endproperty
    a_ack: assert property (p_ack) else $error("grant kept after acknowledge");
    property p_float; (!grant_acknowledge_n) [*3] ##0 address_strobe_n |-> addr_oe_n && ctl_oe_n; endproperty
    a_float: assert property (p_float) else $error("bus driven while owned");
    // Fault ends the running cycle; reset leaves the bus idle and driven
    property p_fault; $fell(bus_fault_in_n) && !address_strobe_n |-> ##[1:5] address_strobe_n; endproperty
    a_fault: assert property (p_fault) else $error("fault did not end cycle");
    property p_reset; $past(sys_rst) |-> bus_grant_n && address_strobe_n && !addr_oe_n; endproperty
    a_reset: assert property (p_reset) else $error("reset state");
    c_word: cover property (!upper_byte_strobe_n && !lower_byte_strobe_n && !read_write);
    c_owned: cover property (!grant_acknowledge_n && addr_oe_n);
    c_fault: cover property ($fell(bus_fault_in_n));
endmodule : cpu_bus_cycle_arbitration_ctrl_checker
`default_nettype wire

// ==== verif/cpu_bus_cycle_arbitration_ctrl_bench.sv ====
// Self-checking bench joining the processor end and the external end.
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_cycle_arbitration_ctrl_bench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc_start, cyc_write, cyc_word, cyc_tas, cyc_supervisor, cyc_program, cyc_int_ack;
    logic want_bus, rerun_on_fault, halt_hold, cyc_ready, cyc_done, exc_done, halted;
    logic owns_bus, fault_issued;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_wdata, rd_val, cyc_rdata, seen_data, sr_val, frame_sr;
    logic [31:0] exc_new_pc;
    logic [7:0] ack_delay, own_len;
    logic [2:0] seen_fc;
    logic [1:0] seen_strb;
    int bad_count = 0, num_checks = 0, as_falls = 0, base, i;
    // Read qualifiers and the code each must show
    localparam logic [29:0] read_quals = {6'h10, 6'h12, 6'h14, 6'h16, 6'h15};
    localparam logic [14:0] read_codes = {3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    cpu_bus_if bus ();
    always #2 clk_sys = ~clk_sys;
    cpu_bus_end i_cpu_bus_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus),
        .cyc_start(cyc_start), .cyc_write(cyc_write), .cyc_word(cyc_word), .cyc_tas(cyc_tas),
        .cyc_supervisor(cyc_supervisor), .cyc_program(cyc_program), .cyc_int_ack(cyc_int_ack),
        .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .stack_ptr(24'h001000),
        .prog_counter(24'h002468), .status_word(sr_val), .cyc_ready(cyc_ready),
        .cyc_done(cyc_done), .exc_done(exc_done), .halted(halted), .cyc_rdata(cyc_rdata),
        .exc_new_pc(exc_new_pc));
    // Short watchdog so fault tests finish quickly
    cpu_ext_end #(.WATCH_CYC(4), .HALT_TAIL_CYC(3)) i_cpu_ext_end (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .bus(bus), .want_bus(want_bus), .own_cycles(own_len),
        .ack_delay(ack_delay), .rerun_on_fault(rerun_on_fault), .halt_hold(halt_hold),
        .read_value(rd_val), .owns_bus(owns_bus), .fault_issued(fault_issued));
    cpu_bus_cycle_arbitration_ctrl_checker i_cpu_bus_cycle_arbitration_ctrl_checker (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .addr_oe_n(bus.addr_oe_n),
        .data_oe_n(bus.data_oe_n), .address_strobe_n(bus.address_strobe_n),
        .upper_byte_strobe_n(bus.upper_byte_strobe_n),
        .lower_byte_strobe_n(bus.lower_byte_strobe_n), .read_write(bus.read_write),
        .ctl_oe_n(bus.ctl_oe_n), .cycle_space_code(bus.cycle_space_code), .fc_oe_n(bus.fc_oe_n),
        .bus_request_n(bus.bus_request_n), .bus_grant_n(bus.bus_grant_n),
        .grant_acknowledge_n(bus.grant_acknowledge_n), .bus_fault_in_n(bus.bus_fault_in_n));
    // Snapshot of the last strobed transfer and a count of started cycles
    always @(posedge clk_sys) begin
        if (!bus.address_strobe_n && !(bus.upper_byte_strobe_n && bus.lower_byte_strobe_n)) begin
            seen_data <= bus.data_out;
            seen_fc <= bus.cycle_space_code;
            seen_strb <= {bus.upper_byte_strobe_n, bus.lower_byte_strobe_n};
        end
        if ($fell(bus.address_strobe_n)) as_falls <= as_falls + 1;
        // Status word push of the fault frame lands six bytes below the stack top
        if (!bus.address_strobe_n && !bus.read_write && bus.addr == 23'h0007FD)
            frame_sr <= bus.data_out;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bounded wait; a miss counts as a mismatch rather than hanging
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 300 && s !== 1'b1; n++) @(posedge clk_sys) #1;
        if (s !== 1'b1) check(32'h0, 32'h1);
    endtask : wait_hi
    // Request is raised once ready is seen high and held for one edge only
    task automatic start(input logic [5:0] q, input logic [23:0] a, input logic [15:0] d);
        wait_hi(cyc_ready);
        {cyc_write, cyc_word, cyc_tas, cyc_supervisor, cyc_program, cyc_int_ack} = q;
        cyc_addr = a;
        cyc_wdata = d;
        cyc_start = 1'b1;
        @(posedge clk_sys) #1;
        cyc_start = 1'b0;
    endtask : start
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        {cyc_start, cyc_write, cyc_word, cyc_tas, cyc_supervisor, cyc_program, cyc_int_ack} = '0;
        {want_bus, rerun_on_fault, halt_hold, cyc_addr, cyc_wdata, rd_val} = '0;
        ack_delay = 8'h01;
        own_len = 8'h07;
        sr_val = 16'h2700;
        repeat (20) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        for (i = 0; i < 3; i++) begin
            start((i == 0) ? 6'h30 : 6'h20, 24'h000100 + 24'(i / 2), 16'hA55A);
            wait_hi(cyc_done);
            check(32'(seen_strb), (i == 0) ? 32'h0 : 32'(i));
            if (i == 0) check(32'(seen_data), 32'hA55A);
        end
        $display("test lanes done");
        for (i = 0; i < 5; i++) begin
            rd_val = 16'h1234 + 16'(i);
            start(read_quals[29 - 6 * i -: 6], 24'h000200, 16'h0000);
            wait_hi(cyc_done);
            check(32'(cyc_rdata), 32'(rd_val));
            check(32'(seen_fc), 32'(read_codes[14 - 3 * i -: 3]));
        end
        $display("test codes done");
        // Locked cycle asked as a word still runs on one lane
        base = as_falls;
        rd_val = 16'h0012;
        start(6'h18, 24'h000201, 16'h0000);
        wait_hi(cyc_done);
        check(32'(seen_strb), 32'h2);
        check(32'(seen_data[7:0]), 32'h92);
        check(32'(as_falls - base), 32'h1);
        $display("test locked done");
        // Request raised one edge ahead, so its synchronised copy lands in S0
        want_bus = 1'b1;
        @(posedge clk_sys) #1;
        start(6'h30, 24'h000300, 16'h1111);
        @(posedge clk_sys) #1;
        check(32'(bus.bus_grant_n), 32'h1);
        @(posedge clk_sys) #1;
        check(32'(bus.bus_grant_n), 32'h0);
        wait_hi(cyc_done);
        wait_hi(owns_bus);
        repeat (3) @(posedge clk_sys) #1;
        check(32'({bus.addr_oe_n, bus.ctl_oe_n, bus.fc_oe_n, cyc_ready}), 32'hE);
        want_bus = 1'b0;
        start(6'h30, 24'h000302, 16'h2222);
        wait_hi(cyc_done);
        $display("test arbitration done");
        // Unanswered write: fault, frame of six writes, two vector reads
        ack_delay = 8'hFF;
        rd_val = 16'h00C0;
        base = as_falls;
        start(6'h30, 24'h000400, 16'h3333);
        wait_hi(fault_issued);
        ack_delay = 8'h01;
        wait_hi(exc_done);
        check(exc_new_pc, 32'h00C000C0);
        check(32'(as_falls - base), 32'h9);
        check(32'(seen_fc), 32'h5);
        check(32'(frame_sr), 32'(sr_val));
        $display("test fault done");
        // Fault with halt held: float, stay halted, then repeat the same write
        ack_delay = 8'hFF;
        rerun_on_fault = 1'b1;
        start(6'h20, 24'h000501, 16'h5AA5);
        halt_hold = 1'b1;
        wait_hi(halted);
        check(32'({bus.fc_oe_n, bus.addr_oe_n, bus.data_oe_n}), 32'h7);
        base = as_falls;
        ack_delay = 8'h01;
        rerun_on_fault = 1'b0;
        repeat (6) @(posedge clk_sys) #1;
        check(32'(as_falls - base), 32'h0);
        halt_hold = 1'b0;
        wait_hi(cyc_done);
        check(32'({seen_strb, seen_fc, seen_data[7:0]}), 32'h11A5);
        check(32'(as_falls - base), 32'h1);
        $display("test rerun done");
        complete_run();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        complete_run();
    end
endmodule : cpu_bus_cycle_arbitration_ctrl_bench
`default_nettype wire
